// >>> microcore_shift_unit.sv
// Added by the designer: the register addresses and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
module microcore_shift_unit (
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	output logic             shift_busy,
	output logic             shifted_out_flag,
	output logic             precision_loss_flag,
	output logic             shift_overflow_flag
);
	shift_ctl_if ctl ();

	shift_decoder u_dec (
		.ctl (ctl)
	);

	shift_step u_step (
		.ctl (ctl)
	);

	logic [15:0]              alu_q [shift_pkg::ALU_COUNT];
	logic [15:0]              prod_hi_q;
	logic [15:0]              prod_lo_q;
	shift_pkg::run_state_t    state_q;
	shift_pkg::op_kind_t      kind_q;
	logic [2:0]               dst_q;
	logic [31:0]              work_q;
	logic [15:0]              cnt_q;
	logic                     acc_q;
	logic                     obit_q;
	logic                     loss_q;
	logic                     ovf_q;
	logic                     bad_op_q;
	logic                     pend_q;
	logic                     wr_q;
	logic                     map_q;
	logic                     rdy_q;
	logic [7:0]               addr_q;
	logic [31:0]              hrdata_q;

	logic                     busy;
	logic                     accept;
	logic                     wr_go;
	logic                     rd_load;
	logic                     alu_hit;
	logic [2:0]               alu_idx;
	logic                     instr_wr;
	logic                     legal;
	logic                     is_byte;
	logic [15:0]              amount;
	logic                     launch;
	logic                     byte_go;
	logic                     zero_go;
	logic                     run_go;
	logic [15:0]              dst_val;
	logic [15:0]              byte_res;
	logic                     done_run;
	logic                     kind_right_q;
	logic                     dec_right;
	logic                     flag_upd;
	logic                     flag_right;
	logic                     new_obit;
	logic                     new_evt;
	logic [31:0]              start_val;
	logic                     wb_alu;
	logic                     wb_prod;
	logic [2:0]               wb_idx;
	logic [15:0]              wb_val;
	logic [31:0]              rdata;
	logic [31:0]              status_word;

	// Bus slave: writes stall while a shift runs, reads take one wait state
	assign busy      = state_q == shift_pkg::ST_RUN;
	assign accept    = hsel & htrans[1] & hready;
	assign wr_go     = pend_q & wr_q & ~busy & map_q;
	assign rd_load   = pend_q & ~wr_q & ~rdy_q;
	assign hreadyout = ~pend_q | (wr_q ? ~busy : rdy_q);
	assign hresp     = 1'b0;
	assign hrdata    = hrdata_q;
	assign alu_hit   = addr_q[7:5] == shift_pkg::OFF_ALU_BASE[7:5];
	assign alu_idx   = addr_q[4:2];
	assign instr_wr  = wr_go && addr_q == shift_pkg::OFF_INSTR;

	// Instruction issue
	assign ctl.instr = hwdata[15:0];
	assign legal     = ctl.kind != shift_pkg::K_NONE;
	assign is_byte   = ctl.kind == shift_pkg::K_BYTL || ctl.kind == shift_pkg::K_BYTR;
	assign amount    = ctl.by_imm ? {12'h000, ctl.imm} : alu_q[ctl.src_sel];
	assign launch    = instr_wr & legal;
	assign byte_go   = launch & is_byte;
	assign zero_go   = launch & ~is_byte & (amount == 16'h0000);
	assign run_go    = launch & ~is_byte & (amount != 16'h0000);
	assign dst_val   = alu_q[ctl.dst_sel];
	assign byte_res  = (ctl.kind == shift_pkg::K_BYTL) ? dst_val << shift_pkg::BYTE_SHIFT
		: dst_val >> shift_pkg::BYTE_SHIFT;
	assign start_val = (ctl.kind == shift_pkg::K_PRR) ? {prod_hi_q, prod_lo_q}
		: {16'h0000, dst_val};

	// Stepper control
	assign ctl.step_in     = work_q;
	assign ctl.step_left   = kind_q == shift_pkg::K_SHL || kind_q == shift_pkg::K_SHLS;
	assign ctl.step_signed = kind_q == shift_pkg::K_SHLS || kind_q == shift_pkg::K_SHRS;
	assign ctl.step_wide   = kind_q == shift_pkg::K_PRR;
	assign done_run        = busy && cnt_q == 16'h0001;

	// Condition flags
	assign kind_right_q = kind_q == shift_pkg::K_PRR || kind_q == shift_pkg::K_SHR
		|| kind_q == shift_pkg::K_SHRS;
	assign dec_right = ctl.kind == shift_pkg::K_PRR || ctl.kind == shift_pkg::K_SHR
		|| ctl.kind == shift_pkg::K_SHRS || ctl.kind == shift_pkg::K_BYTR;
	assign flag_upd   = done_run | byte_go | zero_go;
	assign flag_right = done_run ? kind_right_q : dec_right;
	assign new_obit = done_run ? ctl.step_bit
		: byte_go ? (dec_right ? dst_val[shift_pkg::BYTE_SHIFT - 1]
		: dst_val[shift_pkg::BYTE_SHIFT]) : 1'b0;
	assign new_evt = done_run ? (acc_q | ctl.step_lost)
		: byte_go ? (dec_right ? |dst_val[shift_pkg::BYTE_SHIFT - 1:0]
		: |dst_val[15:shift_pkg::BYTE_SHIFT]) : 1'b0;

	// Write-back
	assign wb_prod = done_run && kind_q == shift_pkg::K_PRR;
	assign wb_alu  = (done_run && kind_q != shift_pkg::K_PRR) || byte_go;
	assign wb_idx  = done_run ? dst_q : ctl.dst_sel;
	assign wb_val  = done_run ? ctl.step_out[15:0] : byte_res;

	// Read data
	assign status_word = {27'h0000000, bad_op_q, ovf_q, loss_q, obit_q, busy};
	assign rdata = !map_q ? shift_pkg::WORD_RESET
		: alu_hit ? {16'h0000, alu_q[alu_idx]}
		: (addr_q == shift_pkg::OFF_PROD_HI) ? {16'h0000, prod_hi_q}
		: (addr_q == shift_pkg::OFF_PROD_LO) ? {16'h0000, prod_lo_q}
		: (addr_q == shift_pkg::OFF_STATUS) ? status_word
		: shift_pkg::WORD_RESET;

	assign shift_busy          = busy;
	assign shifted_out_flag    = obit_q;
	assign precision_loss_flag = loss_q;
	assign shift_overflow_flag = ovf_q;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pend_q <= 1'b0;
			wr_q   <= 1'b0;
			map_q  <= 1'b0;
			addr_q <= 8'h00;
		end else if (accept) begin
			pend_q <= 1'b1;
			wr_q   <= hwrite;
			map_q  <= haddr[31:8] == 24'h000000 && hsize == shift_pkg::HSIZE_WORD;
			addr_q <= haddr[7:0];
		end else if (hreadyout) begin
			pend_q <= 1'b0;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rdy_q    <= 1'b0;
			hrdata_q <= shift_pkg::WORD_RESET;
		end else if (rd_load) begin
			rdy_q    <= 1'b1;
			hrdata_q <= rdata;
		end else if (hreadyout) begin
			rdy_q <= 1'b0;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state_q <= shift_pkg::ST_IDLE;
		end else begin
			unique case (state_q)
				shift_pkg::ST_IDLE: begin
					if (run_go) begin
						state_q <= shift_pkg::ST_RUN;
					end
				end
				shift_pkg::ST_RUN: begin
					if (done_run) begin
						state_q <= shift_pkg::ST_IDLE;
					end
				end
				default: begin
					state_q <= shift_pkg::ST_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			work_q <= shift_pkg::WORD_RESET;
			cnt_q  <= shift_pkg::REG_RESET;
			acc_q  <= 1'b0;
			kind_q <= shift_pkg::K_NONE;
			dst_q  <= 3'h0;
		end else if (run_go) begin
			work_q <= start_val;
			cnt_q  <= amount;
			acc_q  <= 1'b0;
			kind_q <= ctl.kind;
			dst_q  <= ctl.dst_sel;
		end else if (busy) begin
			work_q <= ctl.step_out;
			cnt_q  <= cnt_q - 16'h0001;
			acc_q  <= acc_q | ctl.step_lost;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			obit_q   <= 1'b0;
			loss_q   <= 1'b0;
			ovf_q    <= 1'b0;
			bad_op_q <= 1'b0;
		end else begin
			if (flag_upd) begin
				obit_q <= new_obit;
				if (flag_right) begin
					loss_q <= new_evt;
				end else begin
					ovf_q <= new_evt;
				end
			end
			if (instr_wr) begin
				bad_op_q <= ~legal;
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			for (int i = 0; i < shift_pkg::ALU_COUNT; i++) begin
				alu_q[i] <= shift_pkg::REG_RESET;
			end
		end else if (wb_alu) begin
			alu_q[wb_idx] <= wb_val;
		end else if (wr_go && alu_hit) begin
			alu_q[alu_idx] <= hwdata[15:0];
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			prod_hi_q <= shift_pkg::REG_RESET;
			prod_lo_q <= shift_pkg::REG_RESET;
		end else if (wb_prod) begin
			prod_hi_q <= ctl.step_out[31:16];
			prod_lo_q <= ctl.step_out[15:0];
		end else if (wr_go && addr_q == shift_pkg::OFF_PROD_HI) begin
			prod_hi_q <= hwdata[15:0];
		end else if (wr_go && addr_q == shift_pkg::OFF_PROD_LO) begin
			prod_lo_q <= hwdata[15:0];
		end
	end

	// Assertion helpers
	logic [15:0] amt_q;
	logic [15:0] run_len_q;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			amt_q     <= shift_pkg::REG_RESET;
			run_len_q <= shift_pkg::REG_RESET;
		end else if (run_go) begin
			amt_q     <= amount;
			run_len_q <= shift_pkg::REG_RESET;
		end else if (busy) begin
			run_len_q <= run_len_q + 16'h0001;
		end
	end

	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	a_run_length: assert property (done_run |-> run_len_q == amt_q - 16'h0001)
		else $error("shift did not last its amount in cycles");
	a_byte_single: assert property (byte_go |=> !busy ##0 obit_q == $past(new_obit))
		else $error("byte shift not finished in one cycle");
	a_sign_hold: assert property (busy && ctl.step_signed && !done_run
		|=> work_q[15] == $past(work_q[15]))
		else $error("sign bit moved during signed shift");
	a_prod_pair: assert property (wb_prod |=> {prod_hi_q, prod_lo_q} == $past(ctl.step_out))
		else $error("product pair write-back split wrongly");
	a_right_loss: assert property (done_run && kind_right_q
		|=> loss_q == ($past(acc_q) | $past(ctl.step_lost)))
		else $error("precision loss flag wrong after right shift");
	a_left_ovf: assert property (done_run && !kind_right_q
		|=> ovf_q == ($past(acc_q) | $past(ctl.step_lost)) && $stable(loss_q))
		else $error("overflow flag wrong after left shift");
	a_obit_stable: assert property (!flag_upd |=> $stable(obit_q))
		else $error("shifted-out flag changed before completion");
	a_decode_prr: assert property (instr_wr && ctl.instr[15:6] == shift_pkg::ENC_PRR_REG
		&& ctl.instr[2:0] == shift_pkg::ENC_PR_TAIL && alu_q[ctl.src_sel] != 16'h0000
		|=> busy && kind_q == shift_pkg::K_PRR)
		else $error("product right shift by register not started");
	a_write_ready: assert property (pend_q && wr_q && done_run |=> hreadyout)
		else $error("stalled write not answered after the shift");
endmodule

// >>> shift_pkg.sv
package shift_pkg;

	localparam int unsigned DATA_W     = 16;
	localparam int unsigned PAIR_W     = 32;
	localparam int unsigned ALU_COUNT  = 8;
	localparam int unsigned BYTE_SHIFT = 8;

	// Byte addresses of the register map
	localparam logic [7:0] OFF_ALU_BASE = 8'h00;
	localparam logic [7:0] OFF_PROD_HI  = 8'h20;
	localparam logic [7:0] OFF_PROD_LO  = 8'h24;
	localparam logic [7:0] OFF_INSTR    = 8'h28;
	localparam logic [7:0] OFF_STATUS   = 8'h2C;

	// Status register bit positions
	localparam int unsigned ST_BUSY_BIT  = 0;
	localparam int unsigned ST_OBIT_BIT  = 1;
	localparam int unsigned ST_LOSS_BIT  = 2;
	localparam int unsigned ST_OVF_BIT   = 3;
	localparam int unsigned ST_BADOP_BIT = 4;

	// Reset values
	localparam logic [15:0] REG_RESET  = 16'h0000;
	localparam logic [31:0] WORD_RESET = 32'h0000_0000;

	// Bus encodings
	localparam logic [2:0] HSIZE_WORD = 3'h2;

	// Instruction encodings
	localparam logic [9:0]  ENC_PRR_REG = 10'h0E4;
	localparam logic [8:0]  ENC_PRR_IMM = 9'h070;
	localparam logic [2:0]  ENC_PR_TAIL = 3'h5;
	localparam logic [9:0]  ENC_SHL     = 10'h0BA;
	localparam logic [12:0] ENC_BYTL    = 13'h05DF;
	localparam logic [12:0] ENC_BYTR    = 13'h05DE;
	localparam logic [8:0]  ENC_SHLI    = 9'h05A;
	localparam logic [9:0]  ENC_SHLS    = 10'h0B8;
	localparam logic [8:0]  ENC_SHLSI   = 9'h058;
	localparam logic [9:0]  ENC_SHR     = 10'h0B9;
	localparam logic [8:0]  ENC_SHRI    = 9'h059;
	localparam logic [9:0]  ENC_SHRS    = 10'h0B7;

	typedef enum logic [2:0] {
		K_NONE = 3'h0,
		K_PRR  = 3'h1,
		K_SHL  = 3'h2,
		K_SHLS = 3'h3,
		K_SHR  = 3'h4,
		K_SHRS = 3'h5,
		K_BYTL = 3'h6,
		K_BYTR = 3'h7
	} op_kind_t;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b01,
		ST_RUN  = 2'b10
	} run_state_t;

endpackage

// >>> shift_ctl_if.sv
`timescale 1ns/1ps
interface shift_ctl_if;
	logic [15:0]          instr;
	shift_pkg::op_kind_t  kind;
	logic                 by_imm;
	logic [2:0]           dst_sel;
	logic [2:0]           src_sel;
	logic [3:0]           imm;
	logic [31:0]          step_in;
	logic [31:0]          step_out;
	logic                 step_left;
	logic                 step_signed;
	logic                 step_wide;
	logic                 step_bit;
	logic                 step_lost;

	modport decode (input instr, output kind, by_imm, dst_sel, src_sel, imm);
	modport step (input step_in, step_left, step_signed, step_wide,
		output step_out, step_bit, step_lost);
	modport core (output instr, step_in, step_left, step_signed, step_wide,
		input kind, by_imm, dst_sel, src_sel, imm, step_out, step_bit, step_lost);
endinterface

// >>> shift_decoder.sv
`timescale 1ns/1ps
module shift_decoder (
	shift_ctl_if.decode ctl
);
	logic m_prr_reg;
	logic m_prr_imm;
	logic m_shl;
	logic m_bytl;
	logic m_bytr;
	logic m_shli;
	logic m_shls;
	logic m_shlsi;
	logic m_shr;
	logic m_shri;
	logic m_shrs;

	assign m_prr_reg = ctl.instr[15:6] == shift_pkg::ENC_PRR_REG
		&& ctl.instr[2:0] == shift_pkg::ENC_PR_TAIL;
	assign m_prr_imm = ctl.instr[15:7] == shift_pkg::ENC_PRR_IMM
		&& ctl.instr[2:0] == shift_pkg::ENC_PR_TAIL;
	assign m_shl   = ctl.instr[15:6] == shift_pkg::ENC_SHL;
	assign m_bytl  = ctl.instr[15:3] == shift_pkg::ENC_BYTL;
	assign m_bytr  = ctl.instr[15:3] == shift_pkg::ENC_BYTR;
	assign m_shli  = ctl.instr[15:7] == shift_pkg::ENC_SHLI;
	assign m_shls  = ctl.instr[15:6] == shift_pkg::ENC_SHLS;
	assign m_shlsi = ctl.instr[15:7] == shift_pkg::ENC_SHLSI;
	assign m_shr   = ctl.instr[15:6] == shift_pkg::ENC_SHR;
	assign m_shri  = ctl.instr[15:7] == shift_pkg::ENC_SHRI;
	assign m_shrs  = ctl.instr[15:6] == shift_pkg::ENC_SHRS;

	assign ctl.kind = (m_prr_reg | m_prr_imm) ? shift_pkg::K_PRR :
		(m_shl | m_shli) ? shift_pkg::K_SHL :
		(m_shls | m_shlsi) ? shift_pkg::K_SHLS :
		(m_shr | m_shri) ? shift_pkg::K_SHR :
		m_shrs ? shift_pkg::K_SHRS :
		m_bytl ? shift_pkg::K_BYTL :
		m_bytr ? shift_pkg::K_BYTR : shift_pkg::K_NONE;

	// Immediate forms carry a 4-bit count in bits 6..3
	assign ctl.by_imm  = m_prr_imm | m_shli | m_shlsi | m_shri;
	assign ctl.imm     = ctl.instr[6:3];
	assign ctl.src_sel = ctl.instr[5:3];
	assign ctl.dst_sel = ctl.instr[2:0];
endmodule

// >>> shift_step.sv
`timescale 1ns/1ps
module shift_step (
	shift_ctl_if.step ctl
);
	logic [31:0] left_val;
	logic [31:0] right_val;
	logic [31:0] in;

	assign in = ctl.step_in;

	// Signed forms keep bit 15 and move only bits 14..0
	assign left_val = ctl.step_signed ? {16'h0000, in[15], in[13:0], 1'b0}
		: {16'h0000, in[14:0], 1'b0};
	assign right_val = ctl.step_wide ? {1'b0, in[31:1]}
		: ctl.step_signed ? {16'h0000, in[15], in[15:1]}
		: {17'h00000, in[15:1]};

	assign ctl.step_out = ctl.step_left ? left_val : right_val;
	assign ctl.step_bit = ctl.step_left ? (ctl.step_signed ? in[14] : in[15]) : in[0];
	// Left signed overflow: a bit differing from the sign leaves bit 14
	assign ctl.step_lost = (ctl.step_left && ctl.step_signed) ? (in[14] ^ in[15])
		: ctl.step_bit;
endmodule

// >>> test_microcore_shift_unit.sv
`timescale 1ns/1ps
module test_microcore_shift_unit;
	logic        hclk;
	logic        hresetn;
	logic        hsel;
	logic [31:0] haddr;
	logic [1:0]  htrans;
	logic        hwrite;
	logic [2:0]  hsize;
	logic [31:0] hwdata;
	logic [31:0] hrdata;
	logic        hreadyout;
	logic        hresp;
	logic        shift_busy;
	logic        shifted_out_flag;
	logic        precision_loss_flag;
	logic        shift_overflow_flag;
	logic        rd_phase;
	logic [31:0] exp_q[$];
	logic [15:0] m_alu[8];
	logic [15:0] m_hi;
	logic [15:0] m_lo;
	logic        m_obit;
	logic        m_loss;
	logic        m_ovf;
	logic        m_bad;
	logic [2:0]  dst_v;
	logic [2:0]  src_v;
	logic [3:0]  imm_v;
	int          failures;
	int          check_count;

	microcore_shift_unit DUT (
		.hclk               (hclk),
		.hresetn            (hresetn),
		.hsel               (hsel),
		.haddr              (haddr),
		.htrans             (htrans),
		.hwrite             (hwrite),
		.hsize              (hsize),
		.hwdata             (hwdata),
		.hready             (hreadyout),
		.hrdata             (hrdata),
		.hreadyout          (hreadyout),
		.hresp              (hresp),
		.shift_busy         (shift_busy),
		.shifted_out_flag   (shifted_out_flag),
		.precision_loss_flag(precision_loss_flag),
		.shift_overflow_flag(shift_overflow_flag)
	);

	initial begin
		hclk = 1'b0;
		forever #50 hclk = ~hclk;
	end

	task automatic end_sim();
		$display("checks %0d failures %0d", check_count, failures);
		if (failures == 0 && check_count > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		check_count++;
		if (got !== exp) begin
			failures++;
			$display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask

	// Samples hready on the falling edge, where it is settled, then joins the rising edge
	task automatic wait_ready();
		int n;
		n = 0;
		while (1) begin
			@(negedge hclk);
			if (hreadyout === 1'b1) break;
			n++;
			if (n > 200) begin
				failures++;
				$display("wrong value at %0t: bus wait timed out", $time);
				end_sim();
			end
		end
		@(posedge hclk);
	endtask

	task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= a;
		hwrite <= w;
		hsize <= shift_pkg::HSIZE_WORD;
		wait_ready();
		htrans <= 2'h0;
		hsel <= 1'b0;
		hwdata <= d;
		rd_phase <= !w;
		wait_ready();
		rd_phase <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		bus(1'b1, {24'h0, a}, {16'h0, d});
	endtask

	task automatic rd(input logic [31:0] a, input logic [31:0] e);
		exp_q.push_back(e);
		bus(1'b0, a, 32'h0);
	endtask

	task automatic set_alu(input logic [2:0] r, input logic [15:0] v);
		m_alu[r] = v;
		wr({3'h0, r, 2'h0}, v);
	endtask

	function automatic logic [31:0] stat();
		return (32'(m_obit) << shift_pkg::ST_OBIT_BIT) | (32'(m_loss) << shift_pkg::ST_LOSS_BIT) |
			(32'(m_ovf) << shift_pkg::ST_OVF_BIT) | (32'(m_bad) << shift_pkg::ST_BADOP_BIT);
	endfunction

	// Models the shift one bit per step, issues it, and optionally checks timing and results
	task automatic run_op(input int op, input logic [2:0] d, input logic [2:0] s,
		input logic [3:0] imm, input bit look);
		logic [15:0] w;
		logic [31:0] v;
		logic        left;
		logic        sgn;
		logic        wide;
		logic        out;
		int          amt;
		int          n;
		left = (op <= 3) || (op == 7);
		sgn = (op == 2) || (op == 3) || (op == 6);
		wide = op >= 9;
		case (op)
			0: w = {shift_pkg::ENC_SHL, s, d};
			1: w = {shift_pkg::ENC_SHLI, imm, d};
			2: w = {shift_pkg::ENC_SHLS, s, d};
			3: w = {shift_pkg::ENC_SHLSI, imm, d};
			4: w = {shift_pkg::ENC_SHR, s, d};
			5: w = {shift_pkg::ENC_SHRI, imm, d};
			6: w = {shift_pkg::ENC_SHRS, s, d};
			7: w = {shift_pkg::ENC_BYTL, d};
			8: w = {shift_pkg::ENC_BYTR, d};
			9: w = {shift_pkg::ENC_PRR_REG, s, shift_pkg::ENC_PR_TAIL};
			default: w = {shift_pkg::ENC_PRR_IMM, imm, shift_pkg::ENC_PR_TAIL};
		endcase
		if (op == 0 || op == 2 || op == 4 || op == 6 || op == 9) begin
			amt = int'(m_alu[s]);
		end else if (op == 7 || op == 8) begin
			amt = 8;
		end else begin
			amt = int'(imm);
		end
		v = wide ? {m_hi, m_lo} : {16'h0, m_alu[d]};
		m_obit = 1'b0;
		m_bad = 1'b0;
		if (left) m_ovf = 1'b0;
		else m_loss = 1'b0;
		for (int i = 0; i < amt; i++) begin
			if (wide) begin
				out = v[0];
				v = v >> 1;
			end else if (left && sgn) begin
				out = v[14];
				m_ovf = m_ovf | (out != v[15]);
				v[14:0] = {v[13:0], 1'b0};
			end else if (left) begin
				out = v[15];
				m_ovf = m_ovf | out;
				v[15:0] = {v[14:0], 1'b0};
			end else begin
				out = v[0];
				v[14:0] = v[15:1];
				v[15] = sgn ? v[15] : 1'b0;
			end
			m_obit = out;
			if (!left) m_loss = m_loss | out;
		end
		if (wide) {m_hi, m_lo} = v;
		else m_alu[d] = v[15:0];
		wr(shift_pkg::OFF_INSTR, w);
		if (look) begin
			n = 0;
			while (n < 70) begin
				@(negedge hclk);
				if (shift_busy !== 1'b1) break;
				n++;
			end
			chk(32'(n), (op == 7 || op == 8) ? 32'h0 : 32'(amt), "busy cycles");
			chk({29'h0, shifted_out_flag, precision_loss_flag, shift_overflow_flag},
				{29'h0, m_obit, m_loss, m_ovf}, "flag pins");
			if (n >= 70) end_sim();
			@(posedge hclk);
			if (wide) begin
				rd({24'h0, shift_pkg::OFF_PROD_HI}, {16'h0, m_hi});
				rd({24'h0, shift_pkg::OFF_PROD_LO}, {16'h0, m_lo});
			end else begin
				rd({27'h0, d, 2'h0}, {16'h0, m_alu[d]});
			end
			rd({24'h0, shift_pkg::OFF_STATUS}, stat());
		end
	endtask

	// Takes the oldest note whenever a read completes
	always @(negedge hclk) begin
		if (rd_phase === 1'b1 && hreadyout === 1'b1) begin
			chk({31'h0, hresp}, 32'h0, "response");
			if (exp_q.size() == 0) begin
				failures++;
				$display("wrong value at %0t: read with nothing expected", $time);
			end else begin
				chk(hrdata, exp_q.pop_front(), "read data");
			end
		end
	end

	initial begin
		hresetn = 1'b0;
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = shift_pkg::HSIZE_WORD;
		hwdata = 32'h0;
		rd_phase = 1'b0;
		failures = 0;
		check_count = 0;
		m_hi = 16'h0;
		m_lo = 16'h0;
		m_obit = 1'b0;
		m_loss = 1'b0;
		m_ovf = 1'b0;
		m_bad = 1'b0;
		foreach (m_alu[i]) m_alu[i] = 16'h0;
		void'($urandom(6));
		repeat (4) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		for (int a = 0; a < 12; a++) rd(32'(a * 4), 32'h0);
		wr(8'h30, 16'hA5A5);
		rd(32'h30, 32'h0);
		bus(1'b1, 32'h0000_0104, 32'h0000_1234);
		rd(32'h4, 32'h0);
		rd(32'h100, 32'h0);
		for (int op = 0; op < 11; op++) begin
			for (int k = 0; k < 3; k++) begin
				dst_v = 3'($urandom_range(7));
				src_v = dst_v + 3'h1;
				imm_v = (k == 0) ? 4'h0 : (k == 1) ? 4'hF : 4'($urandom_range(15));
				set_alu(dst_v, 16'($urandom));
				set_alu(src_v, {12'h0, imm_v});
				m_hi = 16'($urandom);
				m_lo = 16'($urandom);
				wr(shift_pkg::OFF_PROD_HI, m_hi);
				wr(shift_pkg::OFF_PROD_LO, m_lo);
				run_op(op, dst_v, src_v, imm_v, 1'b1);
			end
		end
		wr(shift_pkg::OFF_INSTR, {9'h04F, 4'h3, 3'h2});
		m_bad = 1'b1;
		rd({24'h0, shift_pkg::OFF_STATUS}, stat());
		rd(32'h8, {16'h0, m_alu[2]});
		run_op(5, 3'h2, 3'h3, 4'h1, 1'b1);
		set_alu(3'h4, 16'h8001);
		run_op(3, 3'h4, 3'h5, 4'hF, 1'b0);
		run_op(8, 3'h4, 3'h5, 4'h0, 1'b1);
		repeat (2) @(posedge hclk);
		if (exp_q.size() != 0) begin
			failures++;
			$display("wrong value at %0t: reads left unanswered", $time);
		end
		end_sim();
	end
endmodule
